// ==== src/rx8ie_defs.svh ====
// Constants for the instruction execute unit
`ifndef RX8IE_DEFS_SVH
`define RX8IE_DEFS_SVH
`define RX8IE_INSTR_W      22
`define RX8IE_PC_W         16
`define RX8IE_DATA_W       8
`define RX8IE_STACK_DEPTH  8
`define RX8IE_STAT_GIE_BIT 5
`define RX8IE_PC_RST       16'h0000
`define RX8IE_DATA_RST     8'h00
`define RX8IE_STAT_RST     8'h00
`endif

// ==== src/rx8ie_pkg.sv ====
// Operation codes for the instruction execute unit
package rx8ie_pkg;
	typedef enum logic [5:0] {
		RX8IE_NOP       = 6'h00,
		RX8IE_JUMP      = 6'h01,
		RX8IE_JCC       = 6'h02,
		RX8IE_CALL      = 6'h03,
		RX8IE_CALLS     = 6'h04,
		RX8IE_RET       = 6'h05,
		RX8IE_RETS      = 6'h06,
		RX8IE_RETI      = 6'h07,
		RX8IE_PUSH      = 6'h08,
		RX8IE_POP       = 6'h09,
		RX8IE_MOVE_IMM  = 6'h0a,
		RX8IE_MOVE_REG  = 6'h0b,
		RX8IE_MOVE_LD   = 6'h0c,
		RX8IE_MOVE_ST   = 6'h0d,
		RX8IE_MOVE_STI  = 6'h0e,
		RX8IE_CMV_CLR   = 6'h0f,
		RX8IE_CMV_SET   = 6'h10,
		RX8IE_SHL       = 6'h11,
		RX8IE_SHLC      = 6'h12,
		RX8IE_SHR       = 6'h13,
		RX8IE_SHRC      = 6'h14,
		RX8IE_SHRA      = 6'h15,
		RX8IE_ONES_COMPLEMENT      = 6'h16,
		RX8IE_TWOS_COMPLEMENT      = 6'h17,
		RX8IE_TWOS_COMPLEMENT_WITH_CARRY     = 6'h18,
		RX8IE_INC       = 6'h19,
		RX8IE_INCC      = 6'h1a,
		RX8IE_DEC       = 6'h1b
	} rx8ie_op_t;
endpackage : rx8ie_pkg

// ==== src/rx8ie_core.sv ====
// Single-cycle execute unit for an 8-bit RISC core
// Behaviour
// - Jump loads PC with immediate or program index; conditional form only if condition; no flags.
// - Stack call shifts stack down, stores PC+1 on top, jumps to target.
// - Index call saves PC+1 in program index; index return loads PC from it.
// - Return pops top into PC; interrupt return also sets global interrupt enable.
// - Push stores program index on stack; pop restores it; both advance PC.
// - Register move writes destination and accumulator; immediate move loads accumulator; only zero.
// - Memory load writes accumulator and register, updates zero; memory stores keep flags.
// - Conditional moves load accumulator; register written when carry clear or set respectively.
// - Shift left inserts 0, old bit 7 to carry, result to accumulator and register.
// - Shift left through carry inserts previous carry, old bit 7 to carry.
// - Logical shift right inserts 0 at bit 7, old bit 0 to carry.
// - Shift right through carry inserts previous carry at bit 7, bit 0 to carry.
// - Arithmetic shift right keeps bit 7, old bit 0 to carry.
// - One's complement inverts operand; only zero flag changes.
// - Two's complement writes inverted plus one; carry set when result zero.
// - Two's complement with carry adds carry; carry set when zero and carry was one.
// - Increment adds one; carry set when result wraps to zero.
// - Increment with carry adds carry; carry set when zero and carry was one.
// - Decrement subtracts one; carry cleared when result is all ones.
// - Unary operations may take their operand from a data memory byte.
// - Zero flag follows accumulator for every instruction that updates it.
// - Global interrupt enable at status bit 5 gates interrupt levels 4 to 2 only; other level bits are not output.
// - Every 22-bit instruction completes in one clock cycle.
`timescale 1ns/1ps
`default_nettype none
`include "rx8ie_defs.svh"
module rx8ie_core (
	input  wire logic                        clk_i,
	input  wire logic                        rst_n_i,
	input  wire logic                        instr_valid_i,
	input  wire rx8ie_pkg::rx8ie_op_t        op_i,
	input  wire logic                        cond_true_i,
	input  wire logic                        use_index_i,
	input  wire logic                        src_mem_i,
	input  wire logic [`RX8IE_PC_W-1:0]      addr_i,
	input  wire logic [`RX8IE_DATA_W-1:0]    imm_i,
	input  wire logic [`RX8IE_DATA_W-1:0]    src_reg_i,
	input  wire logic [`RX8IE_DATA_W-1:0]    mem_rdata_i,
	input  wire logic [`RX8IE_DATA_W-1:0]    irq_level_i,
	output logic [`RX8IE_PC_W-1:0]           pc_o,
	output logic [`RX8IE_PC_W-1:0]           program_index_o,
	output logic [`RX8IE_DATA_W-1:0]         acc_o,
	output logic                             carry_o,
	output logic                             zero_o,
	output logic                             overflow_o,
	output logic                             global_interrupt_enable_o,
	output logic [2:0]                       irq_enabled_o,
	output logic                             reg_we_o,
	output logic [`RX8IE_DATA_W-1:0]         reg_wdata_o,
	output logic                             mem_we_o,
	output logic [`RX8IE_DATA_W-1:0]         mem_wdata_o
);
	localparam int DEPTH = `RX8IE_STACK_DEPTH;
	localparam int PCW   = `RX8IE_PC_W;
	localparam int DW    = `RX8IE_DATA_W;

	logic [PCW-1:0] pc_reg, pc_next;
	logic [PCW-1:0] pidx_reg, pidx_next;
	logic [PCW-1:0] stk_reg  [DEPTH];
	logic [PCW-1:0] stk_next [DEPTH];
	logic [DW-1:0]  acc_reg, acc_next;
	logic           c_reg, c_next, z_reg, z_next, v_reg, v_next;
	logic           gie_reg, gie_next;
	logic           rwe_reg, rwe_next, mwe_reg, mwe_next;
	logic [DW-1:0]  rwd_reg, rwd_next, mwd_reg, mwd_next;
	logic [DW-1:0]  opnd;
	logic [DW-1:0]  res;
	logic           res_c, res_v, upd_a, upd_z, upd_cv;
	logic           push_stk, pop_stk;
	logic [PCW-1:0] pc_inc, target;

	assign pc_inc = pc_reg + 16'h0001;
	assign target = use_index_i ? pidx_reg : addr_i;
	// Memory loads always read the data byte, others follow the source select
	assign opnd   = (src_mem_i || (op_i == rx8ie_pkg::RX8IE_MOVE_LD)) ?
		mem_rdata_i : src_reg_i;

	// Datapath result and flags
	always_comb begin
		res    = opnd;
		res_c  = c_reg;
		res_v  = v_reg;
		upd_a  = 1'b0;
		upd_z  = 1'b0;
		upd_cv = 1'b0;
		unique case (op_i)
			rx8ie_pkg::RX8IE_MOVE_IMM: begin
				res   = imm_i;
				upd_a = 1'b1;
				upd_z = 1'b1;
			end
			rx8ie_pkg::RX8IE_MOVE_REG, rx8ie_pkg::RX8IE_MOVE_LD,
			rx8ie_pkg::RX8IE_CMV_CLR, rx8ie_pkg::RX8IE_CMV_SET: begin
				upd_a = 1'b1;
				upd_z = 1'b1;
			end
			rx8ie_pkg::RX8IE_SHL:  res = {opnd[6:0], 1'b0};
			rx8ie_pkg::RX8IE_SHLC: res = {opnd[6:0], c_reg};
			rx8ie_pkg::RX8IE_SHR:  res = {1'b0, opnd[7:1]};
			rx8ie_pkg::RX8IE_SHRC: res = {c_reg, opnd[7:1]};
			rx8ie_pkg::RX8IE_SHRA: res = {opnd[7], opnd[7:1]};
			rx8ie_pkg::RX8IE_ONES_COMPLEMENT: begin
				res   = ~opnd;
				upd_a = 1'b1;
				upd_z = 1'b1;
			end
			rx8ie_pkg::RX8IE_TWOS_COMPLEMENT:  res = ~opnd + 8'h01;
			rx8ie_pkg::RX8IE_TWOS_COMPLEMENT_WITH_CARRY: res = ~opnd + {7'h00, c_reg};
			rx8ie_pkg::RX8IE_INC:   res = opnd + 8'h01;
			rx8ie_pkg::RX8IE_INCC:  res = opnd + {7'h00, c_reg};
			rx8ie_pkg::RX8IE_DEC:   res = opnd - 8'h01;
			default: res = opnd;
		endcase
		unique case (op_i)
			rx8ie_pkg::RX8IE_SHL, rx8ie_pkg::RX8IE_SHLC: begin
				res_c = opnd[7];
				res_v = res[7] ^ opnd[7];
				upd_cv = 1'b1;
			end
			rx8ie_pkg::RX8IE_SHR, rx8ie_pkg::RX8IE_SHRC, rx8ie_pkg::RX8IE_SHRA: begin
				res_c = opnd[0];
				res_v = res[7] ^ opnd[7];
				upd_cv = 1'b1;
			end
			rx8ie_pkg::RX8IE_TWOS_COMPLEMENT, rx8ie_pkg::RX8IE_INC: begin
				res_c = (res == 8'h00);
				res_v = opnd[7] ^ res[7];
				upd_cv = 1'b1;
			end
			rx8ie_pkg::RX8IE_TWOS_COMPLEMENT_WITH_CARRY, rx8ie_pkg::RX8IE_INCC: begin
				res_c = (res == 8'h00) && c_reg;
				res_v = opnd[7] ^ res[7];
				upd_cv = 1'b1;
			end
			rx8ie_pkg::RX8IE_DEC: begin
				res_c = (res != 8'hFF);
				res_v = opnd[7] ^ res[7];
				upd_cv = 1'b1;
			end
			default: upd_cv = 1'b0;
		endcase
		if (upd_cv) begin
			upd_a = 1'b1;
			upd_z = 1'b1;
		end
	end

	// Architectural state next values
	always_comb begin
		pc_next   = pc_reg;
		pidx_next = pidx_reg;
		acc_next  = acc_reg;
		c_next    = c_reg;
		z_next    = z_reg;
		v_next    = v_reg;
		gie_next  = gie_reg;
		rwe_next  = 1'b0;
		rwd_next  = rwd_reg;
		mwe_next  = 1'b0;
		mwd_next  = mwd_reg;
		push_stk  = 1'b0;
		pop_stk   = 1'b0;
		if (instr_valid_i) begin
			pc_next = pc_inc;
			unique case (op_i)
				rx8ie_pkg::RX8IE_JUMP: pc_next = target;
				rx8ie_pkg::RX8IE_JCC:  if (cond_true_i) pc_next = target;
				rx8ie_pkg::RX8IE_CALL: begin
					push_stk = 1'b1;
					pc_next  = target;
				end
				rx8ie_pkg::RX8IE_CALLS: begin
					pidx_next = pc_inc;
					pc_next   = target;
				end
				rx8ie_pkg::RX8IE_RET: begin
					pop_stk = 1'b1;
					pc_next = stk_reg[0];
				end
				rx8ie_pkg::RX8IE_RETI: begin
					pop_stk  = 1'b1;
					pc_next  = stk_reg[0];
					gie_next = 1'b1;
				end
				rx8ie_pkg::RX8IE_RETS: pc_next = pidx_reg;
				rx8ie_pkg::RX8IE_PUSH: push_stk = 1'b1;
				rx8ie_pkg::RX8IE_POP: begin
					pop_stk   = 1'b1;
					pidx_next = stk_reg[0];
				end
				rx8ie_pkg::RX8IE_MOVE_ST: begin
					mwe_next = 1'b1;
					mwd_next = src_reg_i;
				end
				rx8ie_pkg::RX8IE_MOVE_STI: begin
					mwe_next = 1'b1;
					mwd_next = imm_i;
				end
				default: pc_next = pc_inc;
			endcase
			if (upd_a) begin
				acc_next = res;
				rwd_next = res;
				rwe_next = (op_i != rx8ie_pkg::RX8IE_MOVE_IMM);
				if (op_i == rx8ie_pkg::RX8IE_CMV_CLR)
					rwe_next = !c_reg;
				if (op_i == rx8ie_pkg::RX8IE_CMV_SET)
					rwe_next = c_reg;
			end
			if (upd_z)
				z_next = (res == 8'h00);
			if (upd_cv) begin
				c_next = res_c;
				v_next = res_v;
			end
		end
	end

	// Return stack shifting
	generate
		for (genvar i = 0; i < DEPTH; i++) begin : g_stk
			always_comb begin
				stk_next[i] = stk_reg[i];
				if (push_stk) begin
					if (i == 0)
						stk_next[i] = (op_i == rx8ie_pkg::RX8IE_PUSH) ? pidx_reg : pc_inc;
					else
						stk_next[i] = stk_reg[i-1];
				end else if (pop_stk) begin
					stk_next[i] = (i == DEPTH-1) ? stk_reg[i] : stk_reg[(i+1)%DEPTH];
				end
			end
			always_ff @(posedge clk_i) begin
				if (!rst_n_i)
					stk_reg[i] <= `RX8IE_PC_RST;
				else
					stk_reg[i] <= stk_next[i];
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pc_reg   <= `RX8IE_PC_RST;
			pidx_reg <= `RX8IE_PC_RST;
			acc_reg  <= `RX8IE_DATA_RST;
			c_reg    <= 1'b0;
			z_reg    <= 1'b0;
			v_reg    <= 1'b0;
			gie_reg  <= 1'b0;
			rwe_reg  <= 1'b0;
			rwd_reg  <= `RX8IE_DATA_RST;
			mwe_reg  <= 1'b0;
			mwd_reg  <= `RX8IE_DATA_RST;
		end else begin
			pc_reg   <= pc_next;
			pidx_reg <= pidx_next;
			acc_reg  <= acc_next;
			c_reg    <= c_next;
			z_reg    <= z_next;
			v_reg    <= v_next;
			gie_reg  <= gie_next;
			rwe_reg  <= rwe_next;
			rwd_reg  <= rwd_next;
			mwe_reg  <= mwe_next;
			mwd_reg  <= mwd_next;
		end
	end

	assign pc_o                      = pc_reg;
	assign program_index_o           = pidx_reg;
	assign acc_o                     = acc_reg;
	assign carry_o                   = c_reg;
	assign zero_o                    = z_reg;
	assign overflow_o                = v_reg;
	assign global_interrupt_enable_o = gie_reg;
	// Level requests gated by global enable
	assign irq_enabled_o = irq_level_i[4:2] & {3{gie_reg}};
	assign reg_we_o                  = rwe_reg;
	assign reg_wdata_o               = rwd_reg;
	assign mem_we_o                  = mwe_reg;
	assign mem_wdata_o               = mwd_reg;

	property p_jump;
		@(posedge clk_i) disable iff (!rst_n_i)
		instr_valid_i && op_i == rx8ie_pkg::RX8IE_JUMP |=> pc_o == $past(target);
	endproperty
	a_jump: assert property (p_jump) else $error("jump target wrong");
	property p_jcc_flags;
		@(posedge clk_i) disable iff (!rst_n_i)
		instr_valid_i && op_i == rx8ie_pkg::RX8IE_JCC |=> $stable(carry_o) && $stable(zero_o);
	endproperty
	a_jcc_flags: assert property (p_jcc_flags) else $error("jump changed flags");
	property p_call;
		@(posedge clk_i) disable iff (!rst_n_i)
		instr_valid_i && op_i == rx8ie_pkg::RX8IE_CALL |=> stk_reg[0] == $past(pc_inc);
	endproperty
	a_call: assert property (p_call) else $error("call return address wrong");
	property p_calls;
		@(posedge clk_i) disable iff (!rst_n_i)
		instr_valid_i && op_i == rx8ie_pkg::RX8IE_CALLS |=> program_index_o == $past(pc_inc);
	endproperty
	a_calls: assert property (p_calls) else $error("index call wrong");
	property p_reti;
		@(posedge clk_i) disable iff (!rst_n_i)
		instr_valid_i && op_i == rx8ie_pkg::RX8IE_RETI |=> global_interrupt_enable_o;
	endproperty
	a_reti: assert property (p_reti) else $error("reti left enable low");
	property p_cmv;
		@(posedge clk_i) disable iff (!rst_n_i)
		instr_valid_i && op_i == rx8ie_pkg::RX8IE_CMV_CLR |=> reg_we_o == !$past(c_reg);
	endproperty
	a_cmv: assert property (p_cmv) else $error("conditional move wrong");
	property p_shl;
		@(posedge clk_i) disable iff (!rst_n_i)
		instr_valid_i && op_i == rx8ie_pkg::RX8IE_SHL |=> carry_o == $past(opnd[7]) && !acc_o[0];
	endproperty
	a_shl: assert property (p_shl) else $error("shift left wrong");
	property p_dec;
		@(posedge clk_i) disable iff (!rst_n_i)
		instr_valid_i && op_i == rx8ie_pkg::RX8IE_DEC |=> carry_o == (acc_o != 8'hFF);
	endproperty
	a_dec: assert property (p_dec) else $error("decrement carry wrong");
	property p_zero;
		@(posedge clk_i) disable iff (!rst_n_i)
		instr_valid_i && upd_z |=> zero_o == (acc_o == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_store_flags;
		@(posedge clk_i) disable iff (!rst_n_i)
		instr_valid_i && (op_i == rx8ie_pkg::RX8IE_MOVE_ST || op_i == rx8ie_pkg::RX8IE_MOVE_STI)
		|=> $stable(carry_o) && $stable(zero_o) && $stable(acc_o);
	endproperty
	a_store_flags: assert property (p_store_flags) else $error("store changed flags");
	property p_shra;
		@(posedge clk_i) disable iff (!rst_n_i)
		instr_valid_i && op_i == rx8ie_pkg::RX8IE_SHRA
		|=> acc_o[7] == $past(opnd[7]) && carry_o == $past(opnd[0]);
	endproperty
	a_shra: assert property (p_shra) else $error("arithmetic shift wrong");
	c_calls: cover property (@(posedge clk_i) instr_valid_i && op_i == rx8ie_pkg::RX8IE_CALLS);
	c_call: cover property (@(posedge clk_i) instr_valid_i && op_i == rx8ie_pkg::RX8IE_CALL);
	c_reti: cover property (@(posedge clk_i) instr_valid_i && op_i == rx8ie_pkg::RX8IE_RETI);
	c_inc_wrap: cover property (@(posedge clk_i) instr_valid_i && op_i == rx8ie_pkg::RX8IE_INC
		&& res == 8'h00);
endmodule : rx8ie_core
`default_nettype wire

// ==== dv/rx8ie_mem_model.sv ====
// Data memory byte seen by the execute unit
`timescale 1ns/1ps
`default_nettype none
module rx8ie_mem_model (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       we_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o
);
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_o <= 8'h00;
		end else if (we_i) begin
			rdata_o <= wdata_i;
		end
	end
endmodule : rx8ie_mem_model
`default_nettype wire

// ==== dv/rx8ie_core_tb.sv ====
// Self-checking bench for the execute unit
`timescale 1ns/1ps
`default_nettype none
`include "rx8ie_defs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module rx8ie_core_tb;
	logic                  clk_i = 1'b0, rst_n_i = 1'b0, instr_valid_i = 1'b0;
	logic                  cond_true_i = 1'b0, use_index_i = 1'b0, src_mem_i = 1'b0;
	rx8ie_pkg::rx8ie_op_t  op_i = rx8ie_pkg::RX8IE_NOP;
	logic [15:0]           addr_i = '0, pc_o, program_index_o;
	logic [7:0]            imm_i = '0, src_reg_i = '0, irq_level_i = '0, mem_rdata_i;
	logic [7:0]            acc_o, reg_wdata_o, mem_wdata_o;
	logic                  carry_o, zero_o, overflow_o, global_interrupt_enable_o;
	logic                  reg_we_o, mem_we_o;
	logic [2:0]            irq_enabled_o;
	logic [15:0]           epc = `RX8IE_PC_RST, epi = '0;
	logic [7:0]            eacc = '0, ewd = '0, emwd = '0, m = '0, s2d = '0;
	logic                  ec = 0, ez = 0, ev = 0, egie = 0, ewe = 0, emwe = 0, s2v = 0, vchk = 0;
	logic [7:0][15:0]      est = '0;
	logic [31:0]           seed = 32'd23930;
	int                    n_fail = 0, samples_checked = 0, cyc = 0;

	rx8ie_core dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
		.op_i(op_i), .cond_true_i(cond_true_i), .use_index_i(use_index_i),
		.src_mem_i(src_mem_i), .addr_i(addr_i), .imm_i(imm_i), .src_reg_i(src_reg_i),
		.mem_rdata_i(mem_rdata_i), .irq_level_i(irq_level_i), .pc_o(pc_o),
		.program_index_o(program_index_o), .acc_o(acc_o), .carry_o(carry_o),
		.zero_o(zero_o), .overflow_o(overflow_o),
		.global_interrupt_enable_o(global_interrupt_enable_o),
		.irq_enabled_o(irq_enabled_o), .reg_we_o(reg_we_o), .reg_wdata_o(reg_wdata_o),
		.mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o));

	rx8ie_mem_model dmem (.clk_i(clk_i), .rst_n_i(rst_n_i), .we_i(mem_we_o),
		.wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

	initial begin
		forever #2 clk_i = ~clk_i;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Returns {overflow, carry, result}
	function automatic logic [9:0] alu(input rx8ie_pkg::rx8ie_op_t o, input logic [7:0] x,
		input logic ci);
		logic [7:0] r;
		logic       co;
		r = x;
		co = ci;
		case (o)
			rx8ie_pkg::RX8IE_SHL:   {co, r} = {x[7], x[6:0], 1'b0};
			rx8ie_pkg::RX8IE_SHLC:  {co, r} = {x[7], x[6:0], ci};
			rx8ie_pkg::RX8IE_SHR:   {co, r} = {x[0], 1'b0, x[7:1]};
			rx8ie_pkg::RX8IE_SHRC:  {co, r} = {x[0], ci, x[7:1]};
			rx8ie_pkg::RX8IE_SHRA:  {co, r} = {x[0], x[7], x[7:1]};
			rx8ie_pkg::RX8IE_ONES_COMPLEMENT:  r = ~x;
			rx8ie_pkg::RX8IE_TWOS_COMPLEMENT:  r = ~x + 8'h01;
			rx8ie_pkg::RX8IE_TWOS_COMPLEMENT_WITH_CARRY: r = ~x + {7'h00, ci};
			rx8ie_pkg::RX8IE_INC:   r = x + 8'h01;
			rx8ie_pkg::RX8IE_INCC:  r = x + {7'h00, ci};
			rx8ie_pkg::RX8IE_DEC:   r = x - 8'h01;
			default:                r = x;
		endcase
		if (o inside {rx8ie_pkg::RX8IE_TWOS_COMPLEMENT, rx8ie_pkg::RX8IE_INC}) co = (r == 8'h00);
		if (o inside {rx8ie_pkg::RX8IE_TWOS_COMPLEMENT_WITH_CARRY, rx8ie_pkg::RX8IE_INCC}) co = (r == 8'h00) && ci;
		if (o == rx8ie_pkg::RX8IE_DEC) co = (r != 8'hff);
		return {r[7] ^ x[7], co, r};
	endfunction : alu

	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : test_done

	task automatic step(input rx8ie_pkg::rx8ie_op_t o);
		logic [31:0] w;
		logic [31:0] w2;
		logic [7:0]  x;
		logic [9:0]  u;
		logic [15:0] tg;
		logic [15:0] np;
		@(posedge clk_i);
		#1;
		`CHK("pc", epc, pc_o)
		`CHK("index", epi, program_index_o)
		`CHK("acc", eacc, acc_o)
		`CHK("carry", ec, carry_o)
		`CHK("zero", ez, zero_o)
		`CHK("gie", egie, global_interrupt_enable_o)
		`CHK("irq", irq_level_i[4:2] & {3{egie}}, irq_enabled_o)
		`CHK("reg_we", ewe, reg_we_o)
		`CHK("mem_we", emwe, mem_we_o)
		if (ewe) `CHK("reg_wdata", ewd, reg_wdata_o)
		if (emwe) `CHK("mem_wdata", emwd, mem_wdata_o)
		if (vchk) `CHK("overflow", ev, overflow_o)
		// Store lands in memory two instructions later
		if (s2v) m = s2d;
		s2v = emwe;
		s2d = emwd;
		w = rnd();
		w2 = rnd();
		instr_valid_i = 1'b1;
		op_i = o;
		cond_true_i = w[0];
		use_index_i = w[1];
		src_mem_i = w[2];
		imm_i = w[15:8];
		src_reg_i = (w[4:3] == 2'd0) ? 8'hff : (w[4:3] == 2'd1) ? 8'h00 : w[23:16];
		irq_level_i = w[31:24];
		addr_i = w2[15:0];
		x = src_mem_i ? m : src_reg_i;
		if (o == rx8ie_pkg::RX8IE_MOVE_LD) x = m;
		if (o == rx8ie_pkg::RX8IE_MOVE_IMM) x = imm_i;
		u = alu(o, x, ec);
		tg = use_index_i ? epi : addr_i;
		np = epc + 16'h0001;
		vchk = o inside {[rx8ie_pkg::RX8IE_SHL:rx8ie_pkg::RX8IE_SHRA]};
		ev = u[9];
		if (o == rx8ie_pkg::RX8IE_CALL) est = {est[6:0], np};
		if (o == rx8ie_pkg::RX8IE_PUSH) est = {est[6:0], epi};
		if (o == rx8ie_pkg::RX8IE_POP) epi = est[0];
		if (o inside {rx8ie_pkg::RX8IE_RET, rx8ie_pkg::RX8IE_RETI}) np = est[0];
		if (o inside {rx8ie_pkg::RX8IE_RET, rx8ie_pkg::RX8IE_RETI, rx8ie_pkg::RX8IE_POP})
			est = {est[7], est[7:1]};
		if (o == rx8ie_pkg::RX8IE_RETI) egie = 1'b1;
		if (o inside {rx8ie_pkg::RX8IE_JUMP, rx8ie_pkg::RX8IE_CALL, rx8ie_pkg::RX8IE_CALLS}
			|| (o == rx8ie_pkg::RX8IE_JCC && cond_true_i)) np = tg;
		if (o == rx8ie_pkg::RX8IE_RETS) np = epi;
		if (o == rx8ie_pkg::RX8IE_CALLS) epi = epc + 16'h0001;
		emwe = o inside {rx8ie_pkg::RX8IE_MOVE_ST, rx8ie_pkg::RX8IE_MOVE_STI};
		emwd = (o == rx8ie_pkg::RX8IE_MOVE_STI) ? imm_i : src_reg_i;
		if (o inside {[rx8ie_pkg::RX8IE_MOVE_IMM:rx8ie_pkg::RX8IE_MOVE_LD],
			[rx8ie_pkg::RX8IE_CMV_CLR:rx8ie_pkg::RX8IE_DEC]}) begin
			eacc = u[7:0];
			ez = (u[7:0] == 8'h00);
		end
		ewe = o inside {rx8ie_pkg::RX8IE_MOVE_REG, rx8ie_pkg::RX8IE_MOVE_LD,
			[rx8ie_pkg::RX8IE_SHL:rx8ie_pkg::RX8IE_DEC]};
		if (o == rx8ie_pkg::RX8IE_CMV_CLR) ewe = !ec;
		if (o == rx8ie_pkg::RX8IE_CMV_SET) ewe = ec;
		ec = u[8];
		ewd = u[7:0];
		epc = np;
	endtask : step

	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			test_done();
		end
	end

	initial begin
		repeat (5) @(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
		step(rx8ie_pkg::RX8IE_NOP);
		// Overfill the return stack, then unwind past its depth
		repeat (10) step(rx8ie_pkg::RX8IE_CALL);
		repeat (10) step(rx8ie_pkg::RX8IE_RET);
		repeat (2) step(rx8ie_pkg::RX8IE_PUSH);
		repeat (2) step(rx8ie_pkg::RX8IE_POP);
		$display("test stack done");
		for (int k = 0; k < 28; k++) step(rx8ie_pkg::rx8ie_op_t'(6'(k)));
		$display("test codes done");
		repeat (3000) step(rx8ie_pkg::rx8ie_op_t'(6'(rnd() % 32'd28)));
		step(rx8ie_pkg::RX8IE_NOP);
		$display("test random done");
		test_done();
	end
endmodule : rx8ie_core_tb
`default_nettype wire
